// ==== shared/window_lift_consts.svh ====
// constants for the safety window lift controller
`ifndef WINDOW_LIFT_CONSTS_SVH
`define WINDOW_LIFT_CONSTS_SVH

`define WL_POS_W          14
`define WL_CLK_PERIOD_NS  8
`define WL_TICK_PERIOD_NS 1000000
`define WL_TICK_CYCLES    (`WL_TICK_PERIOD_NS / `WL_CLK_PERIOD_NS)

// times in 1 ms ticks
`define WL_LOCKOUT_MS     13'h1388
`define WL_CAL_HOLD_MS    8'hC8
`define WL_IGN_GAP_MS     13'h07D0
`define WL_DOWN_WIN_MS    13'h1388
`define WL_THERM_DELAY_MS 15'h7530
`define WL_RUN_LIMIT_MS   16'h3A98

`define WL_DOWN_PRESSES   2'h3
`define WL_REV_LIMIT      4'hF
`define WL_JAM_FORCE_N    8'h64
`define WL_LOW_VOLT_MV    16'h1D4C

// travel zones and reversal distances in mm below the top
`define WL_ZONE_TOP_MM    9'h004
`define WL_ZONE_NEAR_MM   9'h0FA
`define WL_ZONE_FAR_MM    9'h12C
`define WL_REV_LONG_MM    9'h032
`define WL_REV_HELD_MM    9'h019

`define WL_COOL_SHIFT     8

`endif

// ==== shared/window_lift_pkg.sv ====
// types for the safety window lift controller
`include "window_lift_consts.svh"

package window_lift_pkg;

  typedef struct packed {
    logic autoUp;
    logic manUp;
    logic manDown;
    logic hallPulse;
    logic hallDown;
    logic ignitionOnState;
    logic driverDoorOpen;
    logic lowVoltage;
    logic sleepReq;
    logic supplyLost;
    logic faultDet;
  } pinIn_t;

  typedef struct packed {
    logic up;
    logic down;
  } motorCmd_t;

  typedef struct packed {
    logic                  calibrated;
    logic [`WL_POS_W-1:0]  position;
  } calRec_t;

  typedef enum logic [2:0] {ST_IDLE, ST_MAN_UP, ST_MAN_DOWN, ST_AUTO_UP, ST_REVERSE} motion_t;

  typedef enum logic [1:0] {DS_IDLE, DS_ARMED, DS_IGN_OFF, DS_COUNT} decal_t;

endpackage

// ==== verilog/sync_bits.sv ====
// two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/10ps

module sync_bits #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  initial begin
    if (W < 1) $error("sync_bits: W must be at least 1");
  end

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // sync_bits

// ==== verilog/window_lift_ctrl.sv ====
// safety window lift controller: motion, anti-pinch, calibration, thermal model
// Notes on behaviour
// - auto-up runs with anti-pinch safety active on every door window
// - obstruction force of 100 N during auto-up is a jam and reverses up to 300 mm below top
// - released-switch jam 4 to 250 mm below top drives down to 300 mm
// - jam 250 to 300 mm below top reverses 50 mm, limited by the bottom position
// - jam more than 300 mm below top stops at the jam point
// - jam while auto-up is still held reverses 25 mm
// - 5 s after held reversal auto-up gives plain manual-up without safety
// - held jam after the lockout again reverses 25 mm
// - no jam handling within the top 4 mm of travel
// - uncalibrated after reset or a detected error until taught at closed stop
// - auto held 0.2 s against the closed stop makes the motor calibrated
// - calibration stored to flash on sleep or low supply after switch input
// - calibration recalled from flash on ignition on and after reset
// - uncalibrated disables auto-up and anti-pinch
// - 15 consecutive jam reversals de-calibrate
// - power loss while the motor runs de-calibrates
// - door, bottom, ignition cycle within 2 s, three down presses in 5 s de-calibrate
// - hall count is 0 closed, rises going down, falls going up
// - squared current integral over limit stops motor for 30 s by default
// - thermal stop waits until the running movement ends
// - any motor run is cut after a programmable limit, 15 s by default
`timescale 1ns/10ps
`include "window_lift_consts.svh"

module window_lift_ctrl
  import window_lift_pkg::*;
#(
  parameter int TICK_CYCLES    = `WL_TICK_CYCLES,
  parameter int THERM_DELAY_MS = `WL_THERM_DELAY_MS
) (
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  input  wire pinIn_t               pins,
  input  wire logic [7:0]           forceN,
  input  wire logic [7:0]           motorCurrent,
  input  wire logic [3:0]           countsPerMm,
  input  wire logic [`WL_POS_W-1:0] bottomPos,
  input  wire logic [31:0]          thermalLimit,
  input  wire logic [15:0]          runLimitMs,
  input  wire logic                 flashPageValid,
  input  wire logic                 flashRdValid,
  input  wire calRec_t              flashRdData,
  output motorCmd_t                 motor,
  output logic [`WL_POS_W-1:0]      position,
  output logic                      calibrated,
  output logic                      safetyActive,
  output logic                      autoLockout,
  output logic                      thermalShutdown,
  output logic                      flashWrReq,
  output calRec_t                   flashWrData,
  output logic                      flashRdReq
);

  localparam int PW = `WL_POS_W;

  initial begin
    if (TICK_CYCLES < 2 || TICK_CYCLES > 131071) $error("window_lift_ctrl: TICK_CYCLES out of range");
    if (THERM_DELAY_MS < 1 || THERM_DELAY_MS > 32767) $error("window_lift_ctrl: THERM_DELAY_MS out of range");
  end

  pinIn_t        sw;
  pinIn_t        swPrev_r;
  motion_t       st_r, stNxt;
  decal_t        ds_r, dsNxt;
  logic [16:0]   tickCnt_r;
  logic          tick;
  logic [PW-1:0] pos_r, tgt_r, tgtNxt;
  logic          cal_r, bootDone_r, validSw_r, holdOff_r;
  logic [3:0]    revCnt_r;
  logic [12:0]   lockMs_r, seqMs_r;
  logic [7:0]    stallMs_r;
  logic [15:0]   runMs_r;
  logic [14:0]   thermMs_r;
  logic [31:0]   heat_r;
  logic [1:0]    downCnt_r;
  logic          revHit, lockStart, topReached;

  sync_bits #(.W($bits(pinIn_t))) u_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .d       (pins),
    .q       (sw)
  );

  // distances as hall counts
  function automatic logic [PW-1:0] mmCnt(input logic [8:0] mm, input logic [3:0] cpm);
    logic [12:0] p;
    p     = 13'(mm) * 13'(cpm);
    mmCnt = PW'(p);
  endfunction

  function automatic logic [PW-1:0] downBy(input logic [PW-1:0] p, input logic [PW-1:0] d,
                                           input logic [PW-1:0] bot);
    logic [PW:0] s;
    s      = {1'b0, p} + {1'b0, d};
    downBy = (s > {1'b0, bot}) ? bot : s[PW-1:0];
  endfunction

  wire [PW-1:0] zTop    = mmCnt(`WL_ZONE_TOP_MM, countsPerMm);
  wire [PW-1:0] zNear   = mmCnt(`WL_ZONE_NEAR_MM, countsPerMm);
  wire [PW-1:0] zFar    = mmCnt(`WL_ZONE_FAR_MM, countsPerMm);
  wire [PW-1:0] dLong   = mmCnt(`WL_REV_LONG_MM, countsPerMm);
  wire [PW-1:0] dHeld   = mmCnt(`WL_REV_HELD_MM, countsPerMm);

  wire hallEdge  = sw.hallPulse & ~swPrev_r.hallPulse;
  wire autoRise  = sw.autoUp & ~swPrev_r.autoUp;
  wire anyRise   = |({sw.autoUp, sw.manUp, sw.manDown} & ~{swPrev_r.autoUp, swPrev_r.manUp, swPrev_r.manDown});
  wire downFall  = ~sw.manDown & swPrev_r.manDown;
  wire ignRise   = sw.ignitionOnState & ~swPrev_r.ignitionOnState;
  wire moving    = (st_r != ST_IDLE);
  wire upDrive   = (st_r == ST_MAN_UP) | (st_r == ST_AUTO_UP);
  wire atBottom  = (pos_r >= bottomPos);
  wire autoOk    = cal_r & (lockMs_r == 13'h0000);
  wire jam       = (st_r == ST_AUTO_UP) & cal_r & (forceN >= `WL_JAM_FORCE_N)
                   & (pos_r >= zTop);
  wire calDone   = (st_r == ST_MAN_UP) & sw.autoUp & (stallMs_r >= `WL_CAL_HOLD_MS);
  wire runOver   = moving & (runMs_r >= runLimitMs);
  wire pwrLost   = sw.supplyLost & moving;
  wire overHeat  = heat_r > thermalLimit;
  wire decalArm  = sw.driverDoorOpen & sw.ignitionOnState & atBottom;
  wire decalSeq  = (ds_r == DS_COUNT) & downFall & (downCnt_r == `WL_DOWN_PRESSES - 2'h1);
  wire decalRev  = revHit & (revCnt_r == `WL_REV_LIMIT - 4'h1);
  wire decalNow  = decalSeq | decalRev | pwrLost | sw.faultDet;
  wire storeEv   = ((sw.sleepReq & ~swPrev_r.sleepReq) | (sw.lowVoltage & ~swPrev_r.lowVoltage))
                   & validSw_r & flashPageValid;
  wire [31:0] sq = {16'h0000, 16'(motorCurrent) * 16'(motorCurrent)};
  wire [31:0] heatNxt = heat_r - (heat_r >> `WL_COOL_SHIFT) + (moving ? sq : 32'h0000_0000);

  assign tick = (tickCnt_r == 17'(TICK_CYCLES - 1));

  // motion sequencing
  always_comb begin
    stNxt      = st_r;
    tgtNxt     = tgt_r;
    revHit     = 1'b0;
    lockStart  = 1'b0;
    topReached = 1'b0;
    case (st_r)
      ST_IDLE: begin
        // thermal stop only blocks new movements; a held switch after a cut stays off
        if (!overHeat && thermMs_r == 15'h0000 && !holdOff_r) begin
          if (autoRise && autoOk)
            stNxt = ST_AUTO_UP;
          else if (sw.manUp || sw.autoUp)
            stNxt = ST_MAN_UP;
          else if (sw.manDown && !atBottom)
            stNxt = ST_MAN_DOWN;
        end
      end
      ST_MAN_UP: begin
        if (!(sw.manUp || sw.autoUp) || calDone)
          stNxt = ST_IDLE;
      end
      ST_MAN_DOWN: begin
        if (!sw.manDown || atBottom)
          stNxt = ST_IDLE;
      end
      ST_AUTO_UP: begin
        if (jam) begin
          if (sw.autoUp) begin
            stNxt     = ST_REVERSE;
            tgtNxt    = downBy(pos_r, dHeld, bottomPos);
            revHit    = 1'b1;
            lockStart = 1'b1;
          end else if (pos_r <= zNear) begin
            stNxt  = ST_REVERSE;
            tgtNxt = (zFar > bottomPos) ? bottomPos : zFar;
            revHit = 1'b1;
          end else if (pos_r <= zFar) begin
            stNxt  = ST_REVERSE;
            tgtNxt = downBy(pos_r, dLong, bottomPos);
            revHit = 1'b1;
          end else begin
            stNxt  = ST_IDLE;
          end
        end else if (pos_r == '0) begin
          stNxt      = ST_IDLE;
          topReached = 1'b1;
        end else if (sw.manDown) begin
          stNxt = ST_IDLE;
        end
      end
      ST_REVERSE: begin
        if (pos_r >= tgt_r)
          stNxt = ST_IDLE;
      end
      default: stNxt = ST_IDLE;
    endcase
    if (runOver || pwrLost || decalNow)
      stNxt = ST_IDLE;
  end

  // de-calibration key sequence
  always_comb begin
    dsNxt = ds_r;
    case (ds_r)
      DS_IDLE:    if (decalArm) dsNxt = DS_ARMED;
      DS_ARMED: begin
        if (!sw.ignitionOnState)
          dsNxt = DS_IGN_OFF;
        else if (!decalArm)
          dsNxt = DS_IDLE;
      end
      DS_IGN_OFF: begin
        if (sw.ignitionOnState)
          dsNxt = DS_COUNT;
        else if (seqMs_r >= `WL_IGN_GAP_MS)
          dsNxt = DS_IDLE;
      end
      DS_COUNT: begin
        if (decalSeq || seqMs_r >= `WL_DOWN_WIN_MS || !sw.ignitionOnState)
          dsNxt = DS_IDLE;
      end
      default: dsNxt = DS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tickCnt_r <= 17'h00000;
      swPrev_r  <= '0;
      st_r      <= ST_IDLE;
      ds_r      <= DS_IDLE;
      tgt_r     <= '0;
    end else begin
      tickCnt_r <= tick ? 17'h00000 : tickCnt_r + 17'h00001;
      swPrev_r  <= sw;
      st_r      <= stNxt;
      ds_r      <= dsNxt;
      tgt_r     <= tgtNxt;
    end
  end

  // position count and calibration state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pos_r <= '0;
      cal_r <= 1'b0;
    end else begin
      if (flashRdValid) begin
        pos_r <= flashRdData.position;
        cal_r <= flashRdData.calibrated;
      end else begin
        if (calDone)
          pos_r <= '0;
        else if (hallEdge && sw.hallDown)
          pos_r <= pos_r + PW'(1);
        else if (hallEdge && pos_r != '0)
          pos_r <= pos_r - PW'(1);
        // teaching wins over a clear in the same cycle
        if (calDone)
          cal_r <= 1'b1;
        else if (decalNow)
          cal_r <= 1'b0;
      end
    end
  end

  // millisecond timers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lockMs_r  <= 13'h0000;
      stallMs_r <= 8'h00;
      runMs_r   <= 16'h0000;
      seqMs_r   <= 13'h0000;
      downCnt_r <= 2'h0;
      revCnt_r  <= 4'h0;
      holdOff_r <= 1'b0;
    end else begin
      // without this a held switch would restart the motor right after the cut
      if (runOver || calDone)
        holdOff_r <= 1'b1;
      else if (!(sw.autoUp || sw.manUp || sw.manDown))
        holdOff_r <= 1'b0;
      if (lockStart)
        lockMs_r <= `WL_LOCKOUT_MS;
      else if (tick && lockMs_r != 13'h0000)
        lockMs_r <= lockMs_r - 13'h0001;
      if (!upDrive || hallEdge)
        stallMs_r <= 8'h00;
      else if (tick && stallMs_r != 8'hFF)
        stallMs_r <= stallMs_r + 8'h01;
      if (!moving || stNxt != st_r)
        runMs_r <= 16'h0000;
      else if (tick && runMs_r != 16'hFFFF)
        runMs_r <= runMs_r + 16'h0001;
      if (dsNxt != ds_r)
        seqMs_r <= 13'h0000;
      else if (tick && seqMs_r != 13'h1FFF)
        seqMs_r <= seqMs_r + 13'h0001;
      if (ds_r != DS_COUNT)
        downCnt_r <= 2'h0;
      else if (downFall)
        downCnt_r <= downCnt_r + 2'h1;
      // only a clean run to the top or the de-calibrating reversal ends a streak of reversals
      if (decalRev || topReached)
        revCnt_r <= 4'h0;
      else if (revHit)
        revCnt_r <= revCnt_r + 4'h1;
    end
  end

  // thermal model, leaky integral of squared current
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      heat_r    <= 32'h0000_0000;
      thermMs_r <= 15'h0000;
    end else begin
      if (tick)
        heat_r <= heatNxt;
      if (overHeat && !moving && thermMs_r == 15'h0000)
        thermMs_r <= 15'(THERM_DELAY_MS);
      else if (tick && thermMs_r != 15'h0000)
        thermMs_r <= thermMs_r - 15'h0001;
    end
  end

  // flash store and recall
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bootDone_r  <= 1'b0;
      validSw_r   <= 1'b0;
      flashWrReq  <= 1'b0;
      flashWrData <= '0;
      flashRdReq  <= 1'b0;
    end else begin
      bootDone_r <= 1'b1;
      flashRdReq <= ~bootDone_r | ignRise;
      flashWrReq <= storeEv;
      if (storeEv)
        flashWrData <= '{calibrated: cal_r, position: pos_r};
      // a new press in the store cycle keeps the flag set
      if (anyRise)
        validSw_r <= 1'b1;
      else if (storeEv)
        validSw_r <= 1'b0;
    end
  end

  // registered outputs
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      motor           <= '0;
      safetyActive    <= 1'b0;
      autoLockout     <= 1'b0;
      thermalShutdown <= 1'b0;
    end else begin
      motor.up        <= (stNxt == ST_MAN_UP) | (stNxt == ST_AUTO_UP);
      motor.down      <= (stNxt == ST_MAN_DOWN) | (stNxt == ST_REVERSE);
      safetyActive    <= (stNxt == ST_AUTO_UP) & cal_r;
      autoLockout     <= lockStart | (lockMs_r > 13'h0001);
      thermalShutdown <= (thermMs_r != 15'h0000);
    end
  end

  assign position   = pos_r;
  assign calibrated = cal_r;

endmodule // window_lift_ctrl

// ==== tb/window_glass_model.sv ====
// behavioural glass, motor driver and hall sensor beside the window lift controller
`timescale 1ns/10ps

module window_glass_model
  import window_lift_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      sys_rst,
  input  wire motorCmd_t motor,
  input  wire logic      jamOn,
  input  wire logic [13:0] jamAt,
  input  wire logic [13:0] bottomPos,
  output logic           hallPulse,
  output logic           hallDown,
  output logic [7:0]     forceN,
  output logic [13:0]    glassPos
);
  logic [1:0] phase_r;
  wire        moving = (motor.down && glassPos < bottomPos) || (motor.up && glassPos != 14'h0);
  // obstruction keeps pushing back while the glass is above it
  assign forceN = (jamOn && motor.up && glassPos <= jamAt) ? 8'h64 : 8'h00;
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_r <= 2'h0;
      hallPulse <= 1'h0;
      hallDown <= 1'h0;
      glassPos <= 14'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
      hallPulse <= moving && phase_r == 2'h3;
      if (moving) hallDown <= motor.down;
      if (moving && phase_r == 2'h3) glassPos <= motor.down ? glassPos + 14'h1 : glassPos - 14'h1;
    end
  end
endmodule // window_glass_model

// ==== tb/window_lift_sva.sv ====
// assertions for the window lift controller
`timescale 1ns/10ps
`include "window_lift_consts.svh"

module window_lift_sva
  import window_lift_pkg::*;
#(
  parameter int TICK_CYCLES = 10
) (
  input wire logic                 sys_clk,
  input wire logic                 sys_rst,
  input wire pinIn_t               pins,
  input wire logic [15:0]          runLimitMs,
  input wire logic                 flashPageValid,
  input wire logic                 flashRdValid,
  input wire calRec_t              flashRdData,
  input wire motorCmd_t            motor,
  input wire logic [`WL_POS_W-1:0] position,
  input wire logic                 calibrated,
  input wire logic                 safetyActive,
  input wire logic                 autoLockout,
  input wire logic                 thermalShutdown,
  input wire logic                 flashWrReq,
  input wire logic                 flashRdReq
);
  logic [31:0] runCnt_r;
  logic [31:0] runCnt_nxt;
  // two margin ms for tick phase and sync delay
  assign runCnt_nxt = (motor == 2'h0) ? 32'h0 : runCnt_r + 32'h1;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) runCnt_r <= 32'h0;
    else runCnt_r <= runCnt_nxt;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  safety_needs_cal_a: assert property (safetyActive |-> calibrated)
    else $error("safety armed while uncalibrated");
  safety_auto_up_a: assert property (safetyActive |-> motor.up && !motor.down)
    else $error("safety armed without upward run");
  lockout_no_safety_a: assert property (autoLockout |-> !safetyActive)
    else $error("safety armed during lockout");
  cal_at_top_a: assert property ($rose(calibrated) && !$past(flashRdValid) |-> position == '0)
    else $error("calibrated away from closed stop");
  fault_decal_a: assert property (pins.faultDet |-> ##[1:4] !calibrated)
    else $error("error did not drop calibration");
  therm_idle_start_a: assert property ($rose(thermalShutdown) |-> motor == 2'h0)
    else $error("thermal stop cut a running move");
  therm_refuse_a: assert property (thermalShutdown && motor == 2'h0 ##1 thermalShutdown |-> motor == 2'h0)
    else $error("motion started during thermal stop");
  wr_pulse_a: assert property (flashWrReq |-> flashPageValid ##1 !flashWrReq)
    else $error("bad flash store pulse");
  rd_pulse_a: assert property (flashRdReq |=> !flashRdReq)
    else $error("recall request longer than one cycle");
  recall_load_a: assert property (flashRdValid |=> {calibrated, position} == $past(flashRdData))
    else $error("recalled data not loaded");
  run_limit_a: assert property (runCnt_r <= (32'(runLimitMs) + 32'h2) * TICK_CYCLES)
    else $error("motor run exceeded limit");

  armed_c: cover property (safetyActive);
  lockout_c: cover property (autoLockout);
  thermal_c: cover property (thermalShutdown);
  store_c: cover property (flashWrReq);
endmodule // window_lift_sva

bind window_lift_ctrl window_lift_sva #(.TICK_CYCLES(TICK_CYCLES)) window_lift_sva_inst (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .pins(pins), .runLimitMs(runLimitMs), .flashPageValid(flashPageValid),
  .flashRdValid(flashRdValid), .flashRdData(flashRdData), .motor(motor), .position(position),
  .calibrated(calibrated), .safetyActive(safetyActive), .autoLockout(autoLockout),
  .thermalShutdown(thermalShutdown), .flashWrReq(flashWrReq), .flashRdReq(flashRdReq));

// ==== tb/safety_window_lift_control_tb.sv ====
// self-checking bench for the window lift controller
`timescale 1ns/10ps
`include "window_lift_consts.svh"

module safety_window_lift_control_tb;
  import window_lift_pkg::*;
  localparam int CPM = 2;
  logic sys_clk, sys_rst, flashPageValid, flashRdValid, jamOn, hallPulse, hallDown;
  logic calibrated, safetyActive, autoLockout, thermalShutdown, flashWrReq, flashRdReq;
  logic [7:0] motorCurrent, forceN;
  logic [31:0] thermalLimit;
  logic [15:0] runLimitMs;
  logic [13:0] jamAt, glassPos;
  logic [`WL_POS_W-1:0] position;
  pinIn_t sw, pins;
  calRec_t flashRdData, flashWrData;
  motorCmd_t motor;
  int errors, n_compared, cycles;

  always_comb begin
    pins = sw;
    pins.hallPulse = hallPulse;
    pins.hallDown = hallDown;
  end

  // short tick keeps every ms figure at 10 cycles
  window_lift_ctrl #(.TICK_CYCLES(10), .THERM_DELAY_MS(20)) window_lift_ctrl_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .pins(pins), .forceN(forceN), .motorCurrent(motorCurrent),
    .countsPerMm(4'h2), .bottomPos(14'h0320), .thermalLimit(thermalLimit), .runLimitMs(runLimitMs),
    .flashPageValid(flashPageValid), .flashRdValid(flashRdValid), .flashRdData(flashRdData), .motor(motor),
    .position(position), .calibrated(calibrated), .safetyActive(safetyActive), .autoLockout(autoLockout),
    .thermalShutdown(thermalShutdown), .flashWrReq(flashWrReq), .flashWrData(flashWrData),
    .flashRdReq(flashRdReq));

  window_glass_model window_glass_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .motor(motor),
    .jamOn(jamOn), .jamAt(jamAt), .bottomPos(14'h0320), .hallPulse(hallPulse), .hallDown(hallDown),
    .forceN(forceN), .glassPos(glassPos));

  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  function automatic logic near(input logic [13:0] v, input int mm);
    return v >= 14'(mm * CPM - 2) && v <= 14'(mm * CPM + 2);
  endfunction

  // hall pulses still in the synchroniser land before the count is compared
  task automatic waitIdle();
    int quiet;
    quiet = 0;
    step(6);
    for (int i = 0; i < 4000 && quiet < 8; i++) begin
      step(1);
      quiet = (motor === 2'h0) ? quiet + 1 : 0;
    end
    check("motor idle", quiet, 8);
    check("hall count", position, glassPos);
  endtask

  task automatic autoJam(input int mm, input logic hold);
    jamAt = 14'(mm * CPM);
    jamOn = 1'h1;
    sw.autoUp = 1'h1;
    step(6);
    check("armed", safetyActive, 1);
    for (int i = 0; i < 4000 && hold && motor.down !== 1'h1; i++) step(1);
    sw.autoUp = 1'h0;
    waitIdle();
  endtask

  task automatic recall(input calRec_t rec);
    for (int i = 0; i < 10 && flashRdReq !== 1'h1; i++) step(1);
    check("recall request", flashRdReq, 1);
    flashRdData = rec;
    flashRdValid = 1'h1;
    step(1);
    flashRdValid = 1'h0;
    check("recalled", {calibrated, position}, rec);
  endtask

  initial begin
    sys_rst = 1'h1;
    sw = '0;
    jamOn = 1'h0;
    jamAt = 14'h0;
    motorCurrent = 8'h10;
    thermalLimit = '1;
    runLimitMs = 16'h3A98;
    flashPageValid = 1'h1;
    flashRdValid = 1'h0;
    flashRdData = '0;
    step(2);
    sys_rst = 1'h0;
    step(1);
    check("reset state", {motor, calibrated, position}, 0);
    recall('0);
    sw.autoUp = 1'h1;
    step(6);
    check("uncal auto", {motor.up, safetyActive}, 2'h2);
    step(1400);
    sw.autoUp = 1'h0;
    waitIdle();
    check("short hold", calibrated, 0);
    sw.autoUp = 1'h1;
    step(2200);
    check("taught", {calibrated, position}, 15'h4000);
    sw.autoUp = 1'h0;
    waitIdle();
    sw.manDown = 1'h1;
    for (int i = 0; i < 4000 && position < 14'(200 * CPM); i++) step(1);
    sw.manDown = 1'h0;
    waitIdle();
    autoJam(150, 1'h0);
    check("near zone", near(position, 300), 1);
    autoJam(280, 1'h0);
    check("far zone", near(position, 330), 1);
    autoJam(320, 1'h0);
    check("stop at jam", near(position, 320), 1);
    autoJam(200, 1'h1);
    check("held jam", {near(position, 225), autoLockout}, 2'h3);
    sw.autoUp = 1'h1;
    step(6);
    check("lockout manual up", {motor.up, safetyActive}, 2'h2);
    step(30);
    sw.autoUp = 1'h0;
    waitIdle();
    runLimitMs = 16'h0014;
    sw.manDown = 1'h1;
    step(260);
    check("run cut", motor, 0);
    sw.manDown = 1'h0;
    runLimitMs = 16'h3A98;
    waitIdle();
    motorCurrent = 8'hFF;
    sw.manDown = 1'h1;
    step(6);
    thermalLimit = 32'h0000_0100;
    step(100);
    check("move kept", {motor.down, thermalShutdown}, 2'h2);
    sw.manDown = 1'h0;
    waitIdle();
    step(20);
    check("overheat", thermalShutdown, 1);
    thermalLimit = '1;
    sw.manDown = 1'h1;
    step(10);
    check("refused", motor, 0);
    sw.manDown = 1'h0;
    step(250);
    check("cooled", thermalShutdown, 0);
    flashPageValid = 1'h0;
    sw.sleepReq = 1'h1;
    step(10);
    check("page invalid", flashWrReq, 0);
    sw.sleepReq = 1'h0;
    flashPageValid = 1'h1;
    step(2);
    sw.sleepReq = 1'h1;
    for (int i = 0; i < 10 && flashWrReq !== 1'h1; i++) step(1);
    check("stored", {flashWrReq, flashWrData}, {2'h3, position});
    sw.sleepReq = 1'h0;
    sw.ignitionOnState = 1'h1;
    recall('{1'h1, 14'h0050});
    sw.faultDet = 1'h1;
    step(6);
    check("error decal", calibrated, 0);
    sw.faultDet = 1'h0;
    tally_and_finish();
  end
endmodule // safety_window_lift_control_tb
